/* File: include/split_bus_cfg.svh */
// constants for the split-phase memory bus responder
`ifndef SPLIT_BUS_CFG_SVH
`define SPLIT_BUS_CFG_SVH

// length codes seen on the request length field
`define LEN_W 4
`define LEN_WORD 4'h2
`define LEN_PAIR 4'h3
`define LEN_QUAD 4'h5
`define LEN_LINE 4'h6

// data beats (64-bit word pairs) per length code
`define BEATS_ONE 3'h1
`define BEATS_QUAD 3'h2
`define BEATS_LINE 3'h4

// bus geometry
`define ADDR_W 32
`define DATA_W 64
`define LANES 8
`define LANE_W 8
`define PAIR_LSB 3
`define BEAT_W 3

// delay line from data-valid to the data cycle; read data leaves a stage
// early because its own output flop adds the second clock
`define PIPE_N 3
`define RD_STG 1
`define WR_STG 2

// request queue
`define QUEUE_DEPTH 4
`define QPTR_W 2
`define QCNT_W 3

`endif

/* File: include/split_bus_pkg.sv */
// types shared by the split-phase memory bus responder
package split_bus_pkg;

  // data-cycle sequencer states, gray coded along idle -> beat -> dead
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BEAT = 2'b01,
    ST_DEAD = 2'b11
  } seq_state_e;

  // one request taken from the request bus
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [3:0] len;
    logic lock;
  } mem_req_s;

endpackage

/* File: include/word_stream_if.sv */
// valid/ready word stream between the responder and its write buffer
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: design/two_entry_buffer.sv */
// two-entry buffer with registered valid and ready
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  word_stream_if.snk in_s,
  word_stream_if.src out_s
);
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic head_v_r;
  logic tail_v_r;
  logic push;
  logic pop;

  // ready only while the spare slot is free, so no word is ever lost
  assign push = in_s.valid && !tail_v_r;
  assign pop = head_v_r && out_s.ready;
  assign in_s.ready = !tail_v_r;
  assign out_s.valid = head_v_r;
  assign out_s.data = head_r;

  // head slot and its valid flag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      head_v_r <= 1'b0;
      head_r <= '0;
    end else if (ce) begin
      if (!head_v_r || (pop && !tail_v_r)) begin
        head_v_r <= push;
        if (push) begin
          head_r <= in_s.data;
        end
      end else if (pop) begin
        head_r <= tail_r; // tail moves forward
      end
    end
  end

  // tail slot fills only while the head is held
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tail_v_r <= 1'b0;
      tail_r <= '0;
    end else if (ce) begin
      if (pop && tail_v_r) begin
        tail_v_r <= 1'b0;
      end else if (push && head_v_r && !pop) begin
        tail_v_r <= 1'b1;
        tail_r <= in_s.data;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/split_bus_responder.sv */
// memory-side responder for the split request/data memory bus
`timescale 1ns/1ps
`default_nettype none
`include "split_bus_cfg.svh"

// Functional notes
// - Read data appears on the data lines two clocks after each data-valid.
// - Check bits travel in the same clock as their data word.
// - Code 0x6 returns the aligned 32-byte line, ignoring low five address bits.
// - Critical-first low: line returns from its lowest pair upward.
// - Critical-first high: requested pair first, then onward with wrap.
// - Data cycles may have gaps but keep the order fixed on the first.
// - Write: data-valid two clocks before data; requester then drives data and enables.
// - Any reads and any delay may separate locked read and its write.
// - Abort with data-valid ends that transaction; next data-valid is the next one.
// - An aborted burst may run on inside with data-valid kept low.
// - At least one clock separates two abort assertions.
// - Hold leaves the data bus running for outstanding transactions.
// - No data-valid in the clock right after an abort.
module split_bus_responder #(
  parameter int MEM_WORDS = 64,
  parameter int IW = $clog2(MEM_WORDS)
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic request_strobe_n,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic [`LEN_W-1:0] req_len,
  input wire logic req_lock,
  output logic data_cycle_valid,
  output logic critical_first,
  output logic bus_abort,
  input wire logic [`DATA_W-1:0] data_in,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [`LANES-1:0] check_bits_in,
  output logic [`LANES-1:0] check_bits_out,
  output logic check_bits_oe_n,
  input wire logic [`LANES-1:0] byte_enable_n,
  output logic hold,
  input wire logic request_bus_hold_ack,
  input wire logic hold_req,
  input wire logic cwf_enable,
  output logic hold_granted,
  output logic locked,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [IW-1:0] wr_index,
  output logic [`DATA_W-1:0] wr_data,
  output logic [`LANES-1:0] wr_be_n,
  output logic [`LANES-1:0] wr_check_bits
);
  localparam int BW = IW + `DATA_W + 2 * `LANES;

  split_bus_pkg::mem_req_s queue_r [`QUEUE_DEPTH];
  logic [`QPTR_W-1:0] wp_r;
  logic [`QPTR_W-1:0] rp_r;
  logic [`QCNT_W-1:0] qcnt_r;
  split_bus_pkg::seq_state_e state_r;
  split_bus_pkg::mem_req_s cur_r;
  logic [`BEAT_W-1:0] beat_r;
  logic [`BEAT_W-1:0] total_r;
  logic cwf_mode_r;
  logic range_err_r;
  logic data_cycle_valid_r, cwf_r, abort_r;
  logic [`PIPE_N-1:0] pv_r, pwr_r, pab_r;
  logic [`PIPE_N-1:0][IW-1:0] pidx_r;
  logic [`DATA_W-1:0] mem_r [MEM_WORDS];
  logic [`DATA_W-1:0] dout_r;
  logic [`LANES-1:0] cbout_r;
  logic doe_n_r, hold_r, hack_r, locked_r;
  logic push, pop, issue, last_beat;
  logic [IW-1:0] beat_idx;
  logic [IW-1:0] mask;
  logic [`DATA_W-1:0] rd_word, merged;
  logic [`LANES-1:0] rd_check;

  word_stream_if #(.W(BW)) wb_in ();
  word_stream_if #(.W(BW)) wb_out ();

  // beats of 64 bits for a length code
  function automatic logic [`BEAT_W-1:0] beats_of(input logic [`LEN_W-1:0] len);
    logic [`BEAT_W-1:0] b;
    b = `BEATS_ONE;
    if (len == `LEN_LINE) begin
      b = `BEATS_LINE;
    end else if (len == `LEN_QUAD) begin
      b = `BEATS_QUAD;
    end
    return b;
  endfunction

  // request bus is sampled directly, it runs on this clock
  assign push = !request_strobe_n && (qcnt_r != `QCNT_W'(`QUEUE_DEPTH));
  assign last_beat = (beat_r == total_r - `BEAT_W'(1));
  // writes wait for buffer room and no write beat in flight
  assign issue = (state_r == split_bus_pkg::ST_IDLE) ? 1'b0 :
                 (state_r == split_bus_pkg::ST_BEAT) &&
                 (!cur_r.write || (wb_in.ready && !(|(pv_r & pwr_r))));
  assign pop = issue && (last_beat || range_err_r);

  // pair index: aligned block, start pair first when critical-first, then wrap
  assign mask = IW'(total_r - `BEAT_W'(1));
  assign beat_idx = (cur_r.addr[`PAIR_LSB +: IW] & ~mask) |
                    (((cwf_mode_r ? cur_r.addr[`PAIR_LSB +: IW] : '0) + IW'(beat_r)) & mask);

  // request queue, filled even while the request bus is held
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      qcnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        queue_r[wp_r] <= '{addr: req_addr, write: req_write, len: req_len, lock: req_lock};
        wp_r <= wp_r + `QPTR_W'(1);
      end
      if (pop) begin
        rp_r <= rp_r + `QPTR_W'(1);
      end
      qcnt_r <= qcnt_r + `QCNT_W'(push) - `QCNT_W'(pop);
    end
  end

  // lock tracking: any number of reads may sit inside a locked sequence
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      locked_r <= 1'b0;
    end else if (ce && push) begin
      if (req_lock) begin
        locked_r <= 1'b1;
      end else if (req_write) begin
        locked_r <= 1'b0;
      end
    end
  end

  // data-cycle sequencer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= split_bus_pkg::ST_IDLE;
      cur_r <= '0;
      beat_r <= '0;
      total_r <= `BEATS_ONE;
      cwf_mode_r <= 1'b0;
      range_err_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        split_bus_pkg::ST_IDLE: begin
          if (qcnt_r != '0) begin
            cur_r <= queue_r[rp_r];
            beat_r <= '0;
            total_r <= beats_of(queue_r[rp_r].len);
            cwf_mode_r <= cwf_enable && !queue_r[rp_r].write && (queue_r[rp_r].len == `LEN_LINE);
            range_err_r <= |(queue_r[rp_r].addr >> (`PAIR_LSB + IW));
            state_r <= split_bus_pkg::ST_BEAT;
          end
        end
        split_bus_pkg::ST_BEAT: begin
          if (issue) begin
            beat_r <= beat_r + `BEAT_W'(1);
            if (range_err_r) begin
              state_r <= split_bus_pkg::ST_DEAD;
            end else if (last_beat) begin
              state_r <= split_bus_pkg::ST_IDLE;
            end
          end
        end
        split_bus_pkg::ST_DEAD: begin
          state_r <= split_bus_pkg::ST_IDLE;
        end
        default: begin
          state_r <= split_bus_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // data-valid, critical-first and abort outputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      data_cycle_valid_r <= 1'b0;
      cwf_r <= 1'b0;
      abort_r <= 1'b0;
    end else if (ce) begin
      data_cycle_valid_r <= issue;
      cwf_r <= issue && cwf_mode_r && (beat_r == '0);
      abort_r <= issue && range_err_r;
    end
  end

  // delay line from data-valid to the data cycle, one stage per clock
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pv_r <= '0;
      pwr_r <= '0;
      pab_r <= '0;
      pidx_r <= '0;
    end else if (ce) begin
      pv_r <= {pv_r[`PIPE_N-2:0], issue};
      pwr_r <= {pwr_r[`PIPE_N-2:0], cur_r.write};
      pab_r <= {pab_r[`PIPE_N-2:0], range_err_r};
      pidx_r <= {pidx_r[`PIPE_N-2:0], beat_idx};
    end
  end

  // per-lane parity and byte merge
  assign rd_word = mem_r[pidx_r[`RD_STG]];
  for (genvar i = 0; i < `LANES; i++) begin : g_lane
    assign rd_check[i] = ^rd_word[i*`LANE_W +: `LANE_W];
    assign merged[i*`LANE_W +: `LANE_W] = wb_out.data[`DATA_W + `LANES + i] ?
      mem_r[wb_out.data[BW-1 -: IW]][i*`LANE_W +: `LANE_W] :
      wb_out.data[`LANES + i*`LANE_W +: `LANE_W];
  end

  // read data driven two clocks after data-valid, zeros on an aborted cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dout_r <= '0;
      cbout_r <= '0;
      doe_n_r <= 1'b1;
    end else if (ce) begin
      doe_n_r <= !(pv_r[`RD_STG] && !pwr_r[`RD_STG]);
      dout_r <= (pv_r[`RD_STG] && !pwr_r[`RD_STG] && !pab_r[`RD_STG]) ? rd_word : '0;
      cbout_r <= (pv_r[`RD_STG] && !pwr_r[`RD_STG] && !pab_r[`RD_STG]) ? rd_check : '0;
    end
  end

  // write data taken in its data cycle; enables pass through unchanged
  assign wb_in.valid = pv_r[`WR_STG] && pwr_r[`WR_STG] && !pab_r[`WR_STG];
  assign wb_in.data = {pidx_r[`WR_STG], byte_enable_n, data_in, check_bits_in};
  assign wb_out.ready = wr_ready;

  two_entry_buffer #(.W(BW)) u_wbuf (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .in_s(wb_in),
    .out_s(wb_out)
  );

  // buffered write words land in the local memory when drained
  always_ff @(posedge core_clk) begin
    if (ce && wb_out.valid && wr_ready) begin
      mem_r[wb_out.data[BW-1 -: IW]] <= merged;
    end
  end

  // hold request out, acknowledge in
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_r <= 1'b0;
      hack_r <= 1'b0;
    end else if (ce) begin
      hold_r <= hold_req;
      hack_r <= request_bus_hold_ack;
    end
  end

  assign data_cycle_valid = data_cycle_valid_r;
  assign critical_first = cwf_r;
  assign bus_abort = abort_r;
  assign data_out = dout_r;
  assign data_oe_n = doe_n_r;
  assign check_bits_out = cbout_r;
  assign check_bits_oe_n = doe_n_r;
  assign hold = hold_r;
  assign hold_granted = hack_r;
  assign locked = locked_r;
  assign wr_valid = wb_out.valid;
  assign wr_index = wb_out.data[BW-1 -: IW];
  assign wr_be_n = wb_out.data[BW-IW-1 -: `LANES];
  assign wr_data = wb_out.data[`LANES +: `DATA_W];
  assign wr_check_bits = wb_out.data[`LANES-1:0];
endmodule
`default_nettype wire

/* File: tb/split_bus_props.sv */
// checker for the responder data-cycle timing
`timescale 1ns/1ps
`default_nettype none
module split_bus_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic data_cycle_valid,
  input wire logic critical_first,
  input wire logic bus_abort,
  input wire logic data_oe_n,
  input wire logic check_bits_oe_n,
  input wire logic [63:0] data_out,
  input wire logic [7:0] check_bits_out
);
  // per-byte parity of a data word
  function automatic logic [7:0] lane_par(input logic [63:0] d);
    for (int j = 0; j < 8; j++) lane_par[j] = ^d[8*j +: 8];
  endfunction
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // four back to back beats, and their data two clocks on
  sequence s_beats;
    data_cycle_valid [*4];
  endsequence
  sequence s_drive;
    !data_oe_n [*4];
  endsequence
  AST_DATA_LAG: assert property (!data_oe_n |-> $past(data_cycle_valid, 2))
    else $error("data without data cycle");
  AST_CHECK_BITS: assert property ((check_bits_oe_n == data_oe_n) && (data_oe_n || check_bits_out == lane_par(data_out)))
    else $error("check bits apart from data");
  AST_CWF_FIRST: assert property (critical_first |-> data_cycle_valid && !$past(data_cycle_valid))
    else $error("critical first not on first cycle");
  AST_CWF_BEATS: assert property (critical_first && !bus_abort |-> s_beats)
    else $error("line beats broken");
  AST_CWF_DATA: assert property (critical_first && !bus_abort |-> ##2 s_drive)
    else $error("line data broken");
  AST_ABORT_CYCLE: assert property (bus_abort |-> data_cycle_valid)
    else $error("abort without data cycle");
  AST_ABORT_GAP: assert property (bus_abort |=> !bus_abort)
    else $error("back to back abort");
  AST_DEAD_CYCLE: assert property (bus_abort |=> !data_cycle_valid)
    else $error("data cycle after abort");
endmodule
bind split_bus_responder split_bus_props split_bus_props_i (.core_clk, .rstn, .data_cycle_valid,
  .critical_first, .bus_abort, .data_oe_n, .check_bits_oe_n, .data_out, .check_bits_out);
`default_nettype wire

/* File: tb/requester.sv */
// requesting processor model for the split memory bus
`timescale 1ns/1ps
`default_nettype none
module requester (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic data_cycle_valid,
  input wire logic bus_abort,
  input wire logic hold,
  output logic request_strobe_n,
  output logic [31:0] req_addr,
  output logic req_write,
  output logic [3:0] req_len,
  output logic req_lock,
  output logic [63:0] data_in,
  output logic [7:0] check_bits_in,
  output logic [7:0] byte_enable_n,
  output logic request_bus_hold_ack
);
  logic [3:0] txq[$];
  logic [71:0] wdq[$];
  logic pend_r = 1'b0;
  logic busy_r = 1'b0;
  initial begin
    request_strobe_n = 1'b1;
    {req_addr, req_write, req_len, req_lock} = '0;
    {data_in, check_bits_in} = '0;
    byte_enable_n = 8'hFF;
    request_bus_hold_ack = 1'b0;
  end
  // one request, held back under hold or with four outstanding
  task automatic issue(input logic [31:0] a, input logic w, input logic [3:0] l, input logic k);
    for (int g = 0; g < 3000 && (hold || request_bus_hold_ack || txq.size() >= 4); g++) @(posedge core_clk);
    @(posedge core_clk);
    busy_r <= 1'b1;
    request_strobe_n <= 1'b0;
    req_addr <= a;
    req_write <= w;
    req_len <= l;
    req_lock <= k;
    txq.push_back({w, (l == 4'h6) ? 3'h4 : (l == 4'h5) ? 3'h2 : 3'h1});
    @(posedge core_clk);
    request_strobe_n <= 1'b1;
    req_addr <= ~a;
    req_lock <= ~k;
    busy_r <= 1'b0;
  endtask
  // write data two clocks after each write data cycle without abort, else a changing pattern
  always @(posedge core_clk) begin
    pend_r <= rstn && data_cycle_valid && txq.size() > 0 && txq[0][3] && !bus_abort;
    if (rstn && data_cycle_valid && txq.size() > 0) begin
      if (bus_abort || txq[0][2:0] == 3'h1) void'(txq.pop_front());
      else txq[0][2:0] = txq[0][2:0] - 3'h1;
    end
    if (pend_r && wdq.size() > 0) begin
      {byte_enable_n, data_in} <= wdq[0];
      for (int j = 0; j < 8; j++) check_bits_in[j] <= ^wdq[0][8*j +: 8];
      void'(wdq.pop_front());
    end else begin
      data_in <= ~data_in;
      check_bits_in <= ~check_bits_in;
      byte_enable_n <= 8'hFF;
    end
  end
  // grant the request bus only between requests
  always @(posedge core_clk) request_bus_hold_ack <= rstn && hold && !busy_r;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the split memory bus responder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic hold_req = 1'b0;
  logic cwf_enable = 1'b0;
  logic wr_ready = 1'b0;
  logic stall = 1'b1;
  logic request_strobe_n, req_write, req_lock, data_cycle_valid, critical_first, bus_abort, data_oe_n;
  logic check_bits_oe_n, hold, request_bus_hold_ack, hold_granted, locked, wr_valid;
  logic [31:0] req_addr, rnd;
  logic [3:0] req_len, wr_index;
  logic [63:0] data_in, data_out, wr_data;
  logic [7:0] check_bits_in, check_bits_out, byte_enable_n, wr_be_n, wr_check_bits;
  logic [63:0] mem [16];
  logic [83:0] rq[$], wq[$];
  int seed = 24;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  split_bus_responder #(.MEM_WORDS(16)) split_bus_responder_i (.core_clk, .rstn, .ce, .request_strobe_n,
    .req_addr, .req_write, .req_len, .req_lock, .data_cycle_valid, .critical_first, .bus_abort, .data_in,
    .data_out, .data_oe_n, .check_bits_in, .check_bits_out, .check_bits_oe_n, .byte_enable_n, .hold,
    .request_bus_hold_ack, .hold_req, .cwf_enable, .hold_granted, .locked, .wr_valid, .wr_ready,
    .wr_index, .wr_data, .wr_be_n, .wr_check_bits);
  requester requester_i (.core_clk, .rstn, .data_cycle_valid, .bus_abort, .hold, .request_strobe_n,
    .req_addr, .req_write, .req_len, .req_lock, .data_in, .check_bits_in, .byte_enable_n, .request_bus_hold_ack);
  function automatic logic [7:0] par(input logic [63:0] d);
    for (int j = 0; j < 8; j++) par[j] = ^d[8*j +: 8];
  endfunction
  task automatic cmp(input logic [83:0] e, input logic [83:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic summarize;
    if (rq.size() + wq.size() != 0) begin
      err_total++;
      $display("unexpected at %0t: expected %h notes left, got %h", $time, 0, rq.size() + wq.size());
    end
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // write with random data; expectation noted per beat
  task automatic wr(input logic [31:0] a, input logic [3:0] l, input logic [7:0] be);
    logic [63:0] d;
    logic [3:0] x;
    for (int i = 0; i < ((l == 4'h5) ? 2 : 1); i++) begin
      d = {$random(seed), $random(seed)};
      x = (l == 4'h5) ? {a[6:4], i[0]} : a[6:3];
      for (int j = 0; j < 8; j++) if (!be[j]) mem[x][8*j +: 8] = d[8*j +: 8];
      requester_i.wdq.push_back({be, d});
      wq.push_back({x, be, par(d), d});
    end
    requester_i.issue(a, 1'b1, l, 1'b0);
  endtask
  // read; aborted reads expect zeros once
  task automatic rd(input logic [31:0] a, input logic [3:0] l, input logic k);
    logic [1:0] st;
    st = cwf_enable ? a[4:3] : 2'h0;
    if (|a[31:7]) rq.push_back(84'h0);
    else if (l == 4'h6) for (int i = 0; i < 4; i++) rq.push_back({12'h000, par(mem[{a[6:5], 2'(st + 2'(i))}]),
      mem[{a[6:5], 2'(st + 2'(i))}]});
    else rq.push_back({12'h000, par(mem[a[6:3]]), mem[a[6:3]]});
    requester_i.issue(a, 1'b0, l, k);
  endtask
  task automatic drain;
    for (int g = 0; g < 1000 && rq.size() + wq.size() != 0; g++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
  endtask
  // results taken off the notes as they appear
  always @(posedge core_clk) begin
    if (rstn && !data_oe_n) cmp(rq.size() ? rq.pop_front() : ~84'h0, {12'h000, check_bits_out, data_out});
    if (rstn && wr_valid && wr_ready) cmp(wq.size() ? wq.pop_front() : ~84'h0,
      {wr_index, wr_be_n, wr_check_bits, wr_data});
  end
  // buffer receiver: stalls first, then random
  always @(posedge core_clk) begin
    rnd = $random(seed);
    wr_ready <= !stall && rnd[0];
  end
  // hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    wr(32'h40, 4'h5, 8'h00);
    wr(32'h50, 4'h5, 8'h00);
    wr(32'h00, 4'h5, 8'h00);
    repeat (40) @(posedge core_clk);
    stall <= 1'b0;
    wr(32'h00, 4'h2, 8'hF0);
    wr(32'h08, 4'h3, 8'h7E);
    drain;
    rd(32'h00, 4'h2, 1'b0);
    rd(32'h08, 4'h2, 1'b0);
    rd(32'h100, 4'h6, 1'b0);
    rd(32'h48, 4'h6, 1'b0);
    drain;
    cwf_enable <= 1'b1;
    @(posedge core_clk);
    rd(32'h48, 4'h6, 1'b0);
    drain;
    cwf_enable <= 1'b0;
    rd(32'h40, 4'h2, 1'b1);
    rd(32'h100, 4'h2, 1'b1);
    drain;
    cmp(84'(1), 84'(locked));
    wr(32'h40, 4'h2, 8'hF0);
    drain;
    cmp(84'(0), 84'(locked));
    rd(32'h48, 4'h6, 1'b0);
    hold_req <= 1'b1;
    for (int g = 0; g < 100 && hold_granted !== 1'b1; g++) @(posedge core_clk);
    cmp(84'(1), 84'(hold_granted));
    hold_req <= 1'b0;
    rd(32'h58, 4'h2, 1'b0);
    drain;
    summarize;
  end
endmodule
`default_nettype wire
